// ===== rtl/ubp_burst_ctrl.sv
// Upstream burst profile store and burst launch timing
//
// Overview of operation
// - Symbol rate index 0..4 selects 160k to 2.56M symbols per second, channel wide.
// - One 1024-bit preamble superstring is held per channel for all burst types.
// - A granted burst starts when the local minislot count equals the grant start less the ranging advance.
// - Each well-formed profile is stored while rate_sel is below 5, including 15-bit seed, scrambler enable, guard 5..255.
// - FEC strength 0..10; zero means no coding, else 2*T parity bytes.
// - With coding on, k from 16 to 253, fixed or shortened last codeword.
// - Preamble length up to 1024 bits and offset up to 1022 per burst type.
// - Maximum length zero means variable; grant length 1..255 is then used.
// - A 16-bit unsigned ranging offset in frame tick/64 units advances transmit time.
// - A negative adjustment no larger than the stored offset decreases it so bursts go later; a larger one wraps.
// - Offset is converted to whole symbols of the current rate, then taken off the grant start minislot.
// - Profiles switch back to back unless a timing-sensitive parameter changes; here every burst is followed by the 96 symbol gap.
// - Rate, offset frequency, ranging or modulation change needs a 96 symbol gap.
// - Parameters never change while a burst is being sent.
// - Channel frequency change settles within 100 ms after the gap.
// - Power change settles within 5 us for 1 dB or less, else 10 us.
`timescale 1ns/1ps
`include "ubp_defines.svh"
module ubp_burst_ctrl
  import ubp_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [2:0]   rate_sel,
  input  wire logic [31:0]  chan_freq,
  input  wire logic         sstr_we,
  input  wire logic [4:0]   sstr_addr,
  input  wire logic [31:0]  sstr_data,
  input  wire logic         prof_we,
  input  wire logic [3:0]   prof_type,
  input  wire ubp_profile_t prof_data,
  input  wire logic [5:0]   pwr_level,
  input  wire logic [15:0]  freq_ofs,
  input  wire logic         rng_adj_valid,
  input  wire logic [15:0]  rng_adj,
  input  wire logic         rng_set_valid,
  input  wire logic [15:0]  rng_set,
  input  wire logic         tick_sym,
  input  wire logic         mslot_tick,
  input  wire logic [15:0]  mslot_now,
  input  wire logic         grant_valid,
  input  wire logic [3:0]   grant_type,
  input  wire logic [15:0]  grant_start,
  input  wire logic [7:0]   grant_len,
  output logic              grant_ready,
  output logic              prof_err,
  output logic              burst_start,
  output logic              burst_active,
  output ubp_profile_t      cur_prof,
  output logic [7:0]        cur_len,
  output logic [2:0]        cur_rate,
  output logic [5:0]        cur_pwr,
  output logic [15:0]       cur_fofs,
  output logic [31:0]       cur_freq,
  output logic [15:0]       cur_rng,
  output logic [15:0]       rng_offset,
  output logic [31:0]       pre_word,
  output logic              reconfig_busy
);
  ubp_profile_t prof_mem [`UBP_NUM_TYPES];
  logic [31:0]  sstr_mem [`UBP_SUPERSTR_BITS/32];
  ubp_state_t   state;
  ubp_profile_t pend_prof;
  logic [7:0]   pend_len;
  logic [15:0]  pend_start;
  logic [15:0]  adv_sym;
  logic         launch;
  logic [7:0]   sym_cnt;
  logic [7:0]   len_left;
  logic [7:0]   gap_cnt;
  logic         need_gap;
  logic         need_pwr;
  logic         need_freq;
  logic [5:0]   pwr_diff;
  logic         settle_start;
  logic [23:0]  settle_count;
  logic         settle_busy;

  // Shift of tick/64 units to symbols: 2.56M is 4 units, 160k is 64 units
  function automatic logic [15:0] ubp_to_symbols(input logic [15:0] ofs,
                                                 input logic [2:0] rate);
    logic [15:0] r;
    r = 16'h0000;
    case (rate)
      3'd0:    r = ofs >> 6;
      3'd1:    r = ofs >> 5;
      3'd2:    r = ofs >> 4;
      3'd3:    r = ofs >> 3;
      default: r = ofs >> 2;
    endcase
    return r;
  endfunction : ubp_to_symbols

  function automatic logic ubp_prof_ok(input ubp_profile_t p);
    logic ok;
    ok = 1'b1;
    if (p.pre_len > 11'(`UBP_PRE_LEN_MAX)) ok = 1'b0;
    if (p.pre_ofs > 10'(`UBP_PRE_OFS_MAX)) ok = 1'b0;
    if (p.guard < 8'(`UBP_GUARD_MIN)) ok = 1'b0;
    if (p.fec_t > 4'(`UBP_FEC_T_MAX)) ok = 1'b0;
    if (p.fec_t != 4'h0 && (p.fec_k < 8'(`UBP_K_MIN) || p.fec_k > 8'(`UBP_K_MAX))) ok = 1'b0;
    return ok;
  endfunction : ubp_prof_ok

  // Profile store; malformed profiles are rejected and flagged
  always_ff @(posedge clk_sys) begin
    if (prof_we && ubp_prof_ok(prof_data) && rate_sel < 3'(`UBP_NUM_RATES)) begin
      prof_mem[prof_type] <= prof_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prof_err <= 1'b0;
    end else if (prof_we) begin
      prof_err <= ~ubp_prof_ok(prof_data);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sstr_we) begin
      sstr_mem[sstr_addr] <= sstr_data;
    end
  end

  // Preamble word at the start offset of the active burst type
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_word <= 32'h0000_0000;
    end else begin
      pre_word <= sstr_mem[cur_prof.pre_ofs[9:5]];
    end
  end

  // Ranging offset, unsigned 16 bit, adjustments are two's complement
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rng_offset <= 16'h0000;
    end else if (rng_set_valid) begin
      rng_offset <= rng_set;
    end else if (rng_adj_valid) begin
      rng_offset <= rng_offset + rng_adj;
    end
  end

  // Advance uses the offset and rate the coming burst will be sent with
  assign adv_sym = ubp_to_symbols(rng_offset, rate_sel);
  assign launch  = (state == UBP_WAIT) && mslot_tick && !settle_busy &&
                   ((mslot_now == pend_start - adv_sym) ||
                    (adv_sym == 16'h0000 && mslot_now == pend_start));

  assign grant_ready = (state == UBP_IDLE) || (state == UBP_GAP && gap_cnt == 8'h00);

  // Gap needs between the last burst and the pending one
  assign pwr_diff  = (pwr_level > cur_pwr) ? pwr_level - cur_pwr : cur_pwr - pwr_level;
  assign need_gap  = (rate_sel != cur_rate) || (freq_ofs != cur_fofs) ||
                     (rng_offset != cur_rng) || (chan_freq != cur_freq) ||
                     (pwr_level != cur_pwr) ||
                     (pend_prof.mod_16qam != cur_prof.mod_16qam);
  assign need_freq = (chan_freq != cur_freq);
  assign need_pwr  = (pwr_level != cur_pwr);

  always_comb begin
    settle_count = 24'h00_0000;
    if (need_freq) begin
      settle_count = 24'(`UBP_FREQ_CYC);
    end else if (need_pwr) begin
      settle_count = (pwr_diff <= 6'd1) ? 24'(`UBP_PWR_SMALL_CYC)
                                        : 24'(`UBP_PWR_LARGE_CYC);
    end
  end
  // Settling begins when the grant is taken, so the head-end lead covers it
  assign settle_start = grant_valid && grant_ready && need_gap && !settle_busy &&
                        (settle_count != 24'h00_0000);
  assign reconfig_busy = settle_busy;

  ubp_settle_timer u_settle (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (settle_start),
    .count   (settle_count),
    .busy    (settle_busy)
  );

  // Grant capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_prof  <= '0;
      pend_len   <= 8'h00;
      pend_start <= 16'h0000;
    end else if (grant_valid && grant_ready) begin
      pend_prof  <= prof_mem[grant_type];
      pend_len   <= (prof_mem[grant_type].max_len == 8'h00) ? grant_len
                    : prof_mem[grant_type].max_len;
      pend_start <= grant_start;
    end
  end

  // Burst sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state       <= UBP_IDLE;
      burst_start <= 1'b0;
      sym_cnt     <= 8'h00;
      len_left    <= 8'h00;
    end else begin
      burst_start <= 1'b0;
      case (state)
        UBP_IDLE: begin
          if (grant_valid) begin
            state <= UBP_WAIT;
          end
        end
        UBP_WAIT: begin
          // Launch on the minislot boundary shifted by the ranging advance
          if (launch) begin
            state       <= UBP_TX;
            burst_start <= 1'b1;
            len_left    <= pend_len;
          end
        end
        UBP_TX: begin
          if (mslot_tick) begin
            if (len_left <= 8'h01) begin
              state <= UBP_GAP;
            end
            len_left <= len_left - 8'h01;
          end
        end
        UBP_GAP: begin
          if (grant_valid && gap_cnt == 8'h00) begin
            state <= UBP_WAIT;
          end else if (gap_cnt == 8'h00) begin
            state <= UBP_IDLE;
          end
        end
        default: begin
          state <= UBP_IDLE;
        end
      endcase
      if (tick_sym) begin
        sym_cnt <= sym_cnt + 8'h01;
      end
    end
  end

  // Post-burst symbol gap, counted in symbols
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_cnt <= 8'h00;
    end else if (state == UBP_TX && mslot_tick && len_left <= 8'h01) begin
      gap_cnt <= 8'(`UBP_GAP_SYMBOLS);
    end else if (tick_sym && gap_cnt != 8'h00) begin
      gap_cnt <= gap_cnt - 8'h01;
    end
  end

  assign burst_active = (state == UBP_TX);

  // Profile and length latch while waiting for launch, other parameters only at burst start; none change mid-burst
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_prof <= '0;
      cur_len  <= 8'h00;
      cur_rate <= 3'h0;
      cur_pwr  <= 6'h00;
      cur_fofs <= 16'h0000;
      cur_freq <= 32'h0000_0000;
      cur_rng  <= 16'h0000;
    end else begin
      if (state == UBP_WAIT && gap_cnt == 8'h00) begin
        cur_prof <= pend_prof;
        cur_len  <= pend_len;
      end
      if (launch) begin
        cur_rate <= (rate_sel < 3'(`UBP_NUM_RATES)) ? rate_sel : cur_rate;
        cur_pwr  <= pwr_level;
        cur_fofs <= freq_ofs;
        cur_freq <= chan_freq;
        cur_rng  <= rng_offset;
      end
    end
  end

  a_no_change_tx: assert property (@(posedge clk_sys) disable iff (rst)
    burst_active && $past(burst_active) |-> $stable(cur_rate) && $stable(cur_pwr))
    else $error("parameter changed during burst");
  a_gap_loaded: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(burst_active) |-> gap_cnt == 8'd96)
    else $error("gap not loaded");
  a_start_in_wait: assert property (@(posedge clk_sys) disable iff (rst)
    burst_start |-> $past(state) == UBP_WAIT && $past(mslot_tick))
    else $error("burst start without minislot");
  a_rng_neg_adj: assert property (@(posedge clk_sys) disable iff (rst)
    rng_adj_valid && !rng_set_valid |=> rng_offset == $past(rng_offset) + $past(rng_adj))
    else $error("ranging adjust wrong");
  a_rate_valid: assert property (@(posedge clk_sys) disable iff (rst)
    cur_rate < 3'd5)
    else $error("rate out of range");
  a_fec_range: assert property (@(posedge clk_sys) disable iff (rst)
    prof_we && prof_data.fec_t > 4'd10 |=> prof_err)
    else $error("bad fec not flagged");
  a_k_range: assert property (@(posedge clk_sys) disable iff (rst)
    prof_we && prof_data.fec_t != 4'd0 && prof_data.fec_k < 8'd16 |=> prof_err)
    else $error("bad k not flagged");
  a_no_start_busy: assert property (@(posedge clk_sys) disable iff (rst)
    burst_start |-> !$past(settle_busy))
    else $error("burst during settling");
endmodule : ubp_burst_ctrl

// ===== rtl/ubp_defines.svh
// Constants for the upstream burst profile controller
`ifndef UBP_DEFINES_SVH
`define UBP_DEFINES_SVH
`define UBP_CLK_MHZ          125
`define UBP_NUM_RATES        5
`define UBP_NUM_TYPES        16
`define UBP_SUPERSTR_BITS    1024
`define UBP_PRE_LEN_MAX      1024
`define UBP_PRE_OFS_MAX      1022
`define UBP_GUARD_MIN        5
`define UBP_GUARD_MAX        255
`define UBP_FEC_T_MAX        10
`define UBP_K_MIN            16
`define UBP_K_MAX            253
`define UBP_GAP_SYMBOLS      96
`define UBP_PWR_SMALL_US     5
`define UBP_PWR_LARGE_US     10
`define UBP_FREQ_MS          100
`define UBP_PWR_SMALL_CYC    (`UBP_PWR_SMALL_US * `UBP_CLK_MHZ)
`define UBP_PWR_LARGE_CYC    (`UBP_PWR_LARGE_US * `UBP_CLK_MHZ)
`define UBP_FREQ_CYC         (`UBP_FREQ_MS * 1000 * `UBP_CLK_MHZ)
`endif

// ===== rtl/ubp_pkg.sv
// Types for the upstream burst profile controller
package ubp_pkg;
  typedef struct packed {
    logic        mod_16qam;
    logic        diff_enc;
    logic [10:0] pre_len;
    logic [9:0]  pre_ofs;
    logic [3:0]  fec_t;
    logic [7:0]  fec_k;
    logic [14:0] scr_seed;
    logic        scr_on;
    logic [7:0]  max_len;
    logic [7:0]  guard;
    logic        last_short;
  } ubp_profile_t;
  typedef enum logic [3:0] {
    UBP_IDLE = 4'b0001,
    UBP_WAIT = 4'b0010,
    UBP_TX   = 4'b0100,
    UBP_GAP  = 4'b1000
  } ubp_state_t;
endpackage : ubp_pkg

// ===== rtl/ubp_settle_timer.sv
// Settling timer for reconfiguration between bursts
`timescale 1ns/1ps
module ubp_settle_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [23:0] count,
  output logic             busy
);
  logic [23:0] remain;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remain <= 24'h00_0000;
    end else if (start) begin
      remain <= count;
    end else if (remain != 24'h00_0000) begin
      remain <= remain - 24'h00_0001;
    end
  end
  assign busy = (remain != 24'h00_0000);
endmodule : ubp_settle_timer

// ===== tb/ubp_headend_model.sv
// Head-end timing model: symbol ticks and minislot count as seen at the modem
`timescale 1ns/1ps
module ubp_headend_model #(
  parameter int CYC_PER_SYM  = 2,
  parameter int SYM_PER_SLOT = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  output logic             tick_sym,
  output logic             mslot_tick,
  output logic [15:0]      mslot_now
);
  int cyc;
  int sym;
  // Minislot boundaries follow the timestamp; ticks change off the sampling edge
  always @(negedge clk_sys) begin
    tick_sym   <= 1'b0;
    mslot_tick <= 1'b0;
    if (rst) begin
      cyc       <= 0;
      sym       <= 0;
      mslot_now <= 16'h0000;
    end else if (cyc == CYC_PER_SYM - 1) begin
      cyc      <= 0;
      tick_sym <= 1'b1;
      sym      <= (sym == SYM_PER_SLOT - 1) ? 0 : sym + 1;
      if (sym == SYM_PER_SLOT - 1) begin
        mslot_tick <= 1'b1;
        mslot_now  <= mslot_now + 16'h0001;
      end
    end else begin
      cyc <= cyc + 1;
    end
  end
  initial begin
    tick_sym   = 1'b0;
    mslot_tick = 1'b0;
    mslot_now  = 16'h0000;
    cyc        = 0;
    sym        = 0;
  end
endmodule : ubp_headend_model

// ===== tb/tb_ubp_burst_ctrl.sv
// Self-checking testbench of the burst profile controller
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module tb_ubp_burst_ctrl;
  import ubp_pkg::*;
  typedef struct {logic [3:0] t; logic [2:0] r; ubp_profile_t p; logic [7:0] gl;} ubp_row_t;
  logic clk_sys, rst, sstr_we, prof_we, rng_adj_valid, rng_set_valid, grant_valid;
  logic tick_sym, mslot_tick, grant_ready, prof_err, burst_start, burst_active, reconfig_busy;
  logic [2:0]   rate_sel, cur_rate;
  logic [4:0]   sstr_addr;
  logic [31:0]  sstr_data, pre_word, chan_freq;
  logic [3:0]   prof_type, grant_type;
  ubp_profile_t prof_data, cur_prof;
  ubp_profile_t stored [16];
  logic [5:0]   pwr_level, cur_pwr;
  logic [15:0]  rng_adj, rng_set, mslot_now, grant_start, cur_rng, rng_offset;
  logic [7:0]   grant_len, cur_len;
  int           miscompares, cmp_count, busy_cyc;
  ubp_row_t     rows [5];
  ubp_profile_t bad [6];

  ubp_headend_model i_far (.clk_sys(clk_sys), .rst(rst), .tick_sym(tick_sym),
                           .mslot_tick(mslot_tick), .mslot_now(mslot_now));
  ubp_burst_ctrl i_dut (
    .clk_sys(clk_sys), .rst(rst), .rate_sel(rate_sel), .chan_freq(chan_freq),
    .sstr_we(sstr_we), .sstr_addr(sstr_addr), .sstr_data(sstr_data), .prof_we(prof_we),
    .prof_type(prof_type), .prof_data(prof_data), .pwr_level(pwr_level),
    .freq_ofs(16'h0000), .rng_adj_valid(rng_adj_valid), .rng_adj(rng_adj),
    .rng_set_valid(rng_set_valid), .rng_set(rng_set), .tick_sym(tick_sym),
    .mslot_tick(mslot_tick), .mslot_now(mslot_now), .grant_valid(grant_valid),
    .grant_type(grant_type), .grant_start(grant_start), .grant_len(grant_len),
    .grant_ready(grant_ready), .prof_err(prof_err), .burst_start(burst_start),
    .burst_active(burst_active), .cur_prof(cur_prof), .cur_len(cur_len),
    .cur_rate(cur_rate), .cur_pwr(cur_pwr), .cur_fofs(), .cur_freq(), .cur_rng(cur_rng),
    .rng_offset(rng_offset), .pre_word(pre_word), .reconfig_busy(reconfig_busy));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (reconfig_busy === 1'b1) busy_cyc++;

  function automatic ubp_profile_t mkp(input logic [10:0] pl, input logic [9:0] po,
    input logic [3:0] ft, input logic [7:0] fk, input logic [7:0] ml, input logic [7:0] gd);
    mkp = '{mod_16qam: pl[2], diff_enc: 1'b1, pre_len: pl, pre_ofs: po, fec_t: ft,
            fec_k: fk, scr_seed: 15'h5a5a, scr_on: ft[0], max_len: ml, guard: gd,
            last_short: fk[0]};
  endfunction : mkp

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic wprof(input logic [3:0] t, input ubp_profile_t p);
    prof_type = t;
    prof_data = p;
    prof_we   = 1'b1;
    @(negedge clk_sys);
    prof_we = 1'b0;
    @(negedge clk_sys);
  endtask : wprof

  // Head-end corrections in 1/64 tick units; a negative step larger than the offset wraps
  task automatic rng_op(input logic set, input logic [15:0] v, input logic [15:0] exp);
    rng_set       = v;
    rng_adj       = v;
    rng_set_valid = set;
    rng_adj_valid = ~set;
    @(negedge clk_sys);
    rng_set_valid = 1'b0;
    rng_adj_valid = 1'b0;
    @(negedge clk_sys);
    `CHK(rng_offset, exp)
  endtask : rng_op

  // Head-end keeps the 96 symbol gap plus settling by waiting for ready and a lead
  task automatic burst(input logic [3:0] t, input logic [7:0] gl, input logic [15:0] lead);
    int n;
    logic [15:0] gs;
    n = 0;
    while (grant_ready !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
    gs = mslot_now + lead;
    grant_type  = t;
    grant_start = gs;
    grant_len   = gl;
    grant_valid = 1'b1;
    @(negedge clk_sys);
    grant_valid = 1'b0;
    n = 0;
    while (burst_start !== 1'b1 && n < 4000) begin @(negedge clk_sys); n++; end
    `CHK(burst_start, 1'b1)
    `CHK(mslot_now, gs)
    `CHK(cur_prof, stored[t])
    `CHK(cur_rate, rate_sel)
    `CHK(pre_word, {27'h5a0_0000, stored[t].pre_ofs[9:5]})
    n = 0;
    while (burst_active === 1'b1 && n < 3000) begin
      if (mslot_tick === 1'b1) n++;
      // Only the long-lead type 15 burst changes power, once, mid-burst
      if (n == 1 && lead > 16'h0010) pwr_level = pwr_level | {2'h0, t[3], 3'h0};
      @(negedge clk_sys);
    end
    `CHK(n, int'(gl))
    `CHK(cur_len, gl)
    n = 0;
    while (grant_ready !== 1'b1 && n < 3000) begin
      if (tick_sym === 1'b1) n++;
      @(negedge clk_sys);
    end
    `CHK(n, 96)
  endtask : burst

  initial begin
    {rst, sstr_we, prof_we, rng_adj_valid, rng_set_valid, grant_valid} = 6'h3f ^ 6'h1f;
    {rate_sel, sstr_addr, sstr_data, prof_type, pwr_level} = '0;
    {rng_adj, rng_set, grant_type, grant_start, grant_len} = '0;
    prof_data = '0;
    chan_freq = 32'h0000_0000;
    miscompares = 0;
    cmp_count = 0;
    busy_cyc = 0;
    rows[0] = '{4'h0, 3'h0, mkp(11'h000, 10'h000, 4'h0, 8'h05, 8'h00, 8'h05), 8'h01};
    rows[1] = '{4'h1, 3'h1, mkp(11'h400, 10'h3fe, 4'ha, 8'hfd, 8'h00, 8'hff), 8'hff};
    rows[2] = '{4'h2, 3'h2, mkp(11'h040, 10'h021, 4'h1, 8'h10, 8'h03, 8'h08), 8'h03};
    rows[3] = '{4'hf, 3'h3, mkp(11'h200, 10'h2bc, 4'h5, 8'h64, 8'h02, 8'h14), 8'h02};
    rows[4] = '{4'h7, 3'h4, mkp(11'h004, 10'h3fd, 4'h2, 8'hc8, 8'h00, 8'h09), 8'h04};
    bad[0] = mkp(11'h040, 10'h021, 4'h1, 8'h10, 8'h03, 8'h04);
    bad[1] = mkp(11'h040, 10'h021, 4'hb, 8'h10, 8'h03, 8'h08);
    bad[2] = mkp(11'h040, 10'h021, 4'h1, 8'h0f, 8'h03, 8'h08);
    bad[3] = mkp(11'h040, 10'h021, 4'h1, 8'hfe, 8'h03, 8'h08);
    bad[4] = mkp(11'h040, 10'h3ff, 4'h1, 8'h10, 8'h03, 8'h08);
    bad[5] = mkp(11'h401, 10'h021, 4'h1, 8'h10, 8'h03, 8'h08);
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    `CHK({grant_ready, burst_active, prof_err, rng_offset}, 19'h4_0000)
    for (int a = 0; a < 32; a++) begin
      sstr_addr = a[4:0];
      sstr_data = {27'h5a0_0000, a[4:0]};
      sstr_we   = 1'b1;
      @(negedge clk_sys);
    end
    sstr_we = 1'b0;
    foreach (rows[i]) begin
      stored[rows[i].t] = rows[i].p;
      wprof(rows[i].t, rows[i].p);
      `CHK(prof_err, 1'b0)
      rate_sel = rows[i].r;
      burst(rows[i].t, rows[i].gl, 16'h0003);
    end
    // Profile-only switch back to back must not stall for settling
    busy_cyc = 0;
    burst(4'h2, 8'h03, 16'h0003);
    burst(4'hf, 8'h02, 16'h0003);
    `CHK(busy_cyc, 0)
    foreach (bad[i]) begin
      wprof(4'h2, bad[i]);
      `CHK(prof_err, 1'b1)
    end
    burst(4'h2, 8'h03, 16'h0003);
    // Type 15 flips power mid-burst; the burst must keep its latched level
    pwr_level = 6'h01;
    burst(4'hf, 8'h02, 16'h00c8);
    `CHK(cur_pwr, 6'h01)
    busy_cyc = 0;
    burst(4'h2, 8'h03, 16'h00c8);
    `CHK(cur_pwr, 6'h09)
    `CHK(busy_cyc, 1250)
    pwr_level = 6'h08;
    busy_cyc = 0;
    burst(4'h2, 8'h03, 16'h00c8);
    `CHK(busy_cyc, 625)
    rng_op(1'b1, 16'h0064, 16'h0064);
    rng_op(1'b0, 16'hfffb, 16'h005f);
    rng_op(1'b1, 16'h0002, 16'h0002);
    rng_op(1'b0, 16'hfffb, 16'hfffd);
    rng_op(1'b1, 16'h0003, 16'h0003);
    burst(4'h0, 8'h02, 16'h0003);
    `CHK(cur_rng, 16'h0003)
    report_and_stop();
  end

  initial begin
    #(8 * 60000);
    miscompares++;
    report_and_stop();
  end
endmodule : tb_ubp_burst_ctrl
